// ==== rpt_addr_gen.sv ====
// address stepper for repeated instructions
`timescale 1ns/100ps
module rpt_addr_gen (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // control side
    rpt_addr_if.gen   ai
);
    logic [15:0] addr_r;
    logic [15:0] addr_nxt;

    // load wins over step so a new loop never inherits the old address
    assign addr_nxt = ai.load ? ai.start_addr :
                      ai.step ? 16'(addr_r + 16'h0001) : addr_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_r <= 16'h0000;
        end else begin
            addr_r <= addr_nxt;
        end
    end

    assign ai.addr = addr_r;
endmodule

// ==== rpt_addr_if.sv ====
// carrier between loop control and its address stepper
`timescale 1ns/100ps
interface rpt_addr_if;
    logic        load;
    logic        step;
    logic [15:0] start_addr;
    logic [15:0] addr;
    modport ctrl  (output load, output step, output start_addr, input addr);
    modport gen   (input load, input step, input start_addr, output addr);
endinterface

// ==== rpt_partner.sv ====
// decoder and execution pipeline model facing the repeat unit
`timescale 1ns/100ps
module rpt_partner (
    // clock
    input  wire logic        aclk,
    // decoder side
    output logic             dec_valid,
    input  wire logic        dec_ready,
    output logic             dec_repeat_load,
    output logic             dec_repeat_zero,
    output logic             dec_repeatable,
    output logic [2:0]       dec_class,
    output logic [15:0]      dec_operand,
    output logic [15:0]      dec_addr,
    // pipeline side
    input  wire logic        exec_valid,
    input  wire logic [15:0] exec_addr,
    input  wire logic        exec_once,
    input  wire logic        acc_add_product_register,
    input  wire logic        acc_clear
);
    int          n_exec, n_once, n_acc_add, n_clr, t_first, t_last, cyc;
    logic [15:0] a_first, a_last;
    logic        lost;
    initial begin
        {dec_valid, dec_repeat_load, dec_repeat_zero, dec_repeatable} = 4'h0;
        dec_class = 3'h0;
        {dec_operand, dec_addr} = 32'h0;
        lost = 1'b0;
        cyc = 0;
    end
    task automatic clear();
        {n_exec, n_once, n_acc_add, n_clr} = 0;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (exec_valid === 1'b1) begin
            if (n_exec == 0) begin
                t_first = cyc;
                a_first = exec_addr;
            end
            t_last = cyc;
            a_last = exec_addr;
            n_exec++;
        end
        if (exec_once === 1'b1) n_once++;
        if (acc_add_product_register === 1'b1) n_acc_add++;
        if (acc_clear === 1'b1) n_clr++;
    end
    // offer held until dec_ready is seen at an edge
    task automatic issue(input logic ld, z, rp, input logic [2:0] c, input logic [15:0] op, a);
        int i;
        @(posedge aclk);
        dec_valid <= 1'b1;
        dec_repeat_load <= ld;
        dec_repeat_zero <= z;
        dec_repeatable <= rp;
        dec_class <= c;
        dec_operand <= op;
        dec_addr <= a;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (dec_ready === 1'b1) break;
        end
        if (i == 50) lost = 1'b1;
        // released operands do not keep their last value
        dec_valid <= 1'b0;
        dec_operand <= ~op;
        dec_addr <= ~a;
    endtask
endmodule

// ==== rpt_pkg.sv ====
// constants and types of the single instruction repeat unit
package rpt_pkg;
    localparam int          CNT_W          = 16;
    localparam int          IRQ_W          = 8;
    // register byte offsets
    localparam logic [3:0]  OFS_COUNT      = 4'h0;
    localparam logic [3:0]  OFS_STATUS     = 4'h4;
    localparam logic [15:0] COUNT_RST      = 16'h0000;
    // status bit positions
    localparam int          ST_BUSY        = 0;
    localparam int          ST_MASKED      = 1;
    localparam int          ST_HOLD        = 2;
    localparam int          ST_PEND        = 3;
    localparam int          ST_REJECT      = 4;
    // bus answers
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    // first iteration of a multicycle instruction
    localparam int          CLK_MHZ        = 100;
    localparam int          FIRST_NS       = 30;
    localparam int          FIRST_CYC      = (FIRST_NS * CLK_MHZ + 999) / 1000;
    localparam logic [1:0]  FIRST_WAIT     = 2'(FIRST_CYC - 1);
    typedef enum logic [2:0] {
        CLS_OTHER   = 3'h0,
        CLS_TBL_RD  = 3'h1,
        CLS_TBL_WR  = 3'h2,
        CLS_BLK_D2P = 3'h3,
        CLS_BLK_P2D = 3'h4,
        CLS_BLK_D2D = 3'h5,
        CLS_MUL_MOVE = 3'h6,
        CLS_MULTI   = 3'h7
    } instr_class_t;
    typedef enum logic [2:0] {
        S_IDLE  = 3'b001,
        S_FIRST = 3'b010,
        S_RUN   = 3'b100
    } loop_state_t;
endpackage

// ==== single_instruction_repeat_unit.sv ====
// repeat loop control with register access over axi4-lite
// How it works
// - repeated instruction runs count plus one times
// - full 16-bit range gives 65536 executions
// - count clears on reset, loaded by repeat loads
// - count decrements per execution, loop ends at zero
// - all interrupts masked from repeat decode to end
// - hold requests pause later iterations while loop runs, not the first
// - later iterations of multicycle instructions take one cycle
// - absolute address increments every iteration
// - repeated table read moves one word per cycle
// - only repeatable instructions enter the loop
// - table transfer address starts from accumulator low
// - data to program move starts from block address
// - repeated multiply accumulate with move does all steps
`timescale 1ns/100ps
module single_instruction_repeat_unit (
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // axi4-lite write channels
    input  wire logic [3:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // axi4-lite read channels
    input  wire logic [3:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // instruction decoder
    input  wire logic                 dec_valid,
    output logic                      dec_ready,
    input  wire logic                 dec_repeat_load,
    input  wire logic                 dec_repeat_zero,
    input  wire logic                 dec_repeatable,
    input  wire logic [2:0]           dec_class,
    input  wire logic [15:0]          dec_operand,
    input  wire logic [15:0]          dec_addr,
    // processor state
    input  wire logic [15:0]          accumulator_low_word,
    input  wire logic [15:0]          block_move_address_register,
    // execution pipeline
    output logic                      exec_valid,
    output logic                      exec_first,
    output logic                      exec_last,
    output logic [2:0]                exec_class,
    output logic [15:0]               exec_addr,
    output logic                      exec_once,
    output logic                      acc_clear,
    output logic                      acc_add_product_register,
    output logic                      treg_load,
    output logic                      mult_pmem,
    output logic                      data_move,
    // interrupts
    input  wire logic [rpt_pkg::IRQ_W-1:0] irq_req,
    input  wire logic [rpt_pkg::IRQ_W-1:0] irq_ack,
    output logic [rpt_pkg::IRQ_W-1:0]      irq_out,
    // bus hold pin
    input  wire logic                 hold_req,
    output logic                      hold_ack
);
    rpt_pkg::loop_state_t state_r, state_nxt;
    logic [15:0]               count_r;
    logic [15:0]               count_nxt;
    logic                      armed_r;
    logic [1:0]                first_r;
    logic [2:0]                class_r;
    logic [rpt_pkg::IRQ_W-1:0] pend_r;
    logic                      reject_r;
    logic                      hold_s1_r, hold_s2_r, hold_s3_r, hold_q_r;
    logic                      dec_fire;
    logic                      load_fire;
    logic                      loop_start;
    logic                      step;
    logic                      last_step;
    logic                      masked;
    logic                      sw_count_wr;
    logic [15:0]               start_addr;
    rpt_addr_if                ai ();

    function automatic logic is_multi(input logic [2:0] c);
        is_multi = (rpt_pkg::instr_class_t'(c) != rpt_pkg::CLS_OTHER);
    endfunction

    function automatic logic from_acc(input logic [2:0] c);
        from_acc = (c == rpt_pkg::CLS_TBL_RD) || (c == rpt_pkg::CLS_TBL_WR);
    endfunction

    // hold pin: three flops, a change counts once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_s1_r <= 1'b0;
            hold_s2_r <= 1'b0;
            hold_s3_r <= 1'b0;
            hold_q_r  <= 1'b0;
        end else begin
            hold_s1_r <= hold_req;
            hold_s2_r <= hold_s1_r;
            hold_s3_r <= hold_s2_r;
            if (hold_s2_r == hold_s3_r) begin
                hold_q_r <= hold_s3_r;
            end
        end
    end
    assign hold_ack = hold_q_r;

    // decoder handshake: the decoder stalls while a loop is running
    assign dec_ready  = (state_r == rpt_pkg::S_IDLE);
    assign dec_fire   = dec_valid && dec_ready;
    assign load_fire  = dec_fire && (dec_repeat_load || dec_repeat_zero);
    // an armed repeat only takes a repeatable instruction
    assign loop_start = dec_fire && armed_r && !load_fire && dec_repeatable;
    assign exec_once  = dec_fire && !load_fire && !loop_start;
    assign acc_clear  = load_fire && dec_repeat_zero;

    // iteration: the first waits out the multicycle fill, the rest go
    // one per cycle; hold freezes only these, not the fill counter or the first
    assign step      = ((state_r == rpt_pkg::S_FIRST) && (first_r == 2'h0)) ||
                       ((state_r == rpt_pkg::S_RUN) && !hold_q_r);
    assign last_step = step && (count_r == 16'h0000);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            rpt_pkg::S_IDLE: begin
                if (loop_start) begin
                    state_nxt = rpt_pkg::S_FIRST;
                end
            end
            rpt_pkg::S_FIRST: begin
                if (last_step) begin
                    state_nxt = rpt_pkg::S_IDLE;
                end else if (step) begin
                    state_nxt = rpt_pkg::S_RUN;
                end
            end
            rpt_pkg::S_RUN: begin
                if (last_step) begin
                    state_nxt = rpt_pkg::S_IDLE;
                end
            end
            default: begin
                state_nxt = rpt_pkg::S_IDLE;
            end
        endcase
    end

    // count: repeat loads win, a direct write only lands while idle
    // and unarmed, since loading it mid loop would corrupt the loop
    assign count_nxt = load_fire   ? dec_operand :
                       (step && !last_step) ? 16'(count_r - 16'h0001) :
                       sw_count_wr ? s_axi_wdata[15:0] : count_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r  <= rpt_pkg::S_IDLE;
            count_r  <= rpt_pkg::COUNT_RST;
            armed_r  <= 1'b0;
            first_r  <= 2'h0;
            class_r  <= 3'h0;
            reject_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            if (load_fire) begin
                armed_r <= 1'b1;
            end else if (dec_fire) begin
                armed_r <= 1'b0;
            end
            if (loop_start) begin
                first_r <= is_multi(dec_class) ? rpt_pkg::FIRST_WAIT : 2'h0;
                class_r <= dec_class;
            end else if (first_r != 2'h0) begin
                first_r <= first_r - 2'h1;
            end
            if (dec_fire && armed_r && !load_fire && !dec_repeatable) begin
                reject_r <= 1'b1;
            end else if (load_fire) begin
                reject_r <= 1'b0;
            end
        end
    end

    // start address of the stepped operand
    assign start_addr = from_acc(dec_class) ? accumulator_low_word :
                        (dec_class == rpt_pkg::CLS_BLK_D2P) ?
                        block_move_address_register : dec_addr;
    assign ai.load       = loop_start;
    assign ai.start_addr = start_addr;
    assign ai.step       = step;

    rpt_addr_gen rpt_addr_gen_i (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ai      (ai.gen)
    );

    // pipeline strobes
    assign exec_valid   = step;
    assign exec_first   = step && (state_r == rpt_pkg::S_FIRST);
    assign exec_last    = last_step;
    assign exec_class   = class_r;
    assign exec_addr    = ai.addr;
    assign acc_add_product_register = step && (class_r == rpt_pkg::CLS_MUL_MOVE);
    assign treg_load    = acc_add_product_register;
    assign mult_pmem    = acc_add_product_register;
    assign data_move    = acc_add_product_register;

    // interrupts: reset is the only thing not masked, since it bypasses this unit
    assign masked  = armed_r || (state_r != rpt_pkg::S_IDLE);
    assign irq_out = masked ? '0 : pend_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_r <= '0;
        end else begin
            // a new request wins over an acknowledge in the same cycle
            pend_r <= (pend_r & ~irq_ack) | irq_req;
        end
    end

    // axi4-lite slave: address and data taken together, one of each in flight
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [1:0]  rresp_r;
    logic [31:0] rdata_r;
    logic        wr_fire;
    logic        rd_fire;
    logic        wr_hit_cnt;
    logic        wr_hit_st;
    logic        rd_hit_cnt;
    logic        rd_hit_st;
    logic [31:0] status_w;

    assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign wr_hit_cnt    = (s_axi_awaddr == rpt_pkg::OFS_COUNT);
    assign wr_hit_st     = (s_axi_awaddr == rpt_pkg::OFS_STATUS);
    assign sw_count_wr   = wr_fire && wr_hit_cnt && (s_axi_wstrb[1:0] == 2'h3) &&
                           dec_ready && !armed_r && !load_fire;
    assign rd_fire       = s_axi_arvalid && !rvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign rd_hit_cnt    = (s_axi_araddr == rpt_pkg::OFS_COUNT);
    assign rd_hit_st     = (s_axi_araddr == rpt_pkg::OFS_STATUS);

    always_comb begin
        status_w = 32'h0000_0000;
        status_w[rpt_pkg::ST_BUSY]   = (state_r != rpt_pkg::S_IDLE);
        status_w[rpt_pkg::ST_MASKED] = masked;
        status_w[rpt_pkg::ST_HOLD]   = hold_q_r;
        status_w[rpt_pkg::ST_PEND]   = |pend_r;
        status_w[rpt_pkg::ST_REJECT] = reject_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= rpt_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r  <= rpt_pkg::RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end else begin
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r  <= (wr_hit_cnt || wr_hit_st) ? rpt_pkg::RESP_OKAY :
                                                        rpt_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_r <= 1'b1;
                rresp_r  <= (rd_hit_cnt || rd_hit_st) ? rpt_pkg::RESP_OKAY :
                                                        rpt_pkg::RESP_SLVERR;
                rdata_r  <= rd_hit_cnt ? {16'h0000, count_r} :
                            rd_hit_st  ? status_w : 32'h0000_0000;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp  = rresp_r;
    assign s_axi_rdata  = rdata_r;

    // helper: executions counted against the loaded count
    logic [16:0] iter_r;
    logic [15:0] start_n_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            iter_r    <= 17'h00000;
            start_n_r <= 16'h0000;
        end else if (loop_start) begin
            iter_r    <= 17'h00000;
            start_n_r <= count_r;
        end else if (step) begin
            iter_r <= 17'(iter_r + 17'h00001);
        end
    end

    AST_ITER_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_last |-> (iter_r == {1'b0, start_n_r}))
        else $error("loop did not run count plus one times");
    AST_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
        load_fire |=> (count_r == $past(dec_operand)))
        else $error("repeat load did not set the count");
    AST_DECR: assert property (@(posedge aclk) disable iff (!aresetn)
        (step && !last_step) |=> (count_r == 16'($past(count_r) - 16'h0001)))
        else $error("count not decremented per execution");
    AST_END_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        last_step |=> (state_r == rpt_pkg::S_IDLE) && dec_ready)
        else $error("loop did not end at zero");
    AST_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
        load_fire |=> (irq_out == '0) until (state_r == rpt_pkg::S_IDLE && !armed_r))
        else $error("interrupt passed during repeat loop");
    AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        (hold_q_r && state_r == rpt_pkg::S_RUN) |-> !exec_valid && hold_ack)
        else $error("iteration issued during hold");
    AST_ONE_CYCLE: assert property (@(posedge aclk) disable iff (!aresetn)
        (exec_valid && !exec_last) ##1 !hold_q_r |-> exec_valid)
        else $error("later iteration took more than one cycle");
    AST_ADDR_INC: assert property (@(posedge aclk) disable iff (!aresetn)
        (exec_valid && !exec_last) |=> (exec_addr == 16'($past(exec_addr) + 16'h0001)))
        else $error("address did not advance");
    AST_TBL_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
        (loop_start && dec_class == rpt_pkg::CLS_TBL_RD) |-> ##3 (exec_valid && exec_first))
        else $error("table read first iteration timing wrong");
    AST_REJECT: assert property (@(posedge aclk) disable iff (!aresetn)
        (dec_fire && armed_r && !load_fire && !dec_repeatable) |=> state_r == rpt_pkg::S_IDLE)
        else $error("non repeatable instruction entered loop");
    AST_ACC_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
        (loop_start && dec_class == rpt_pkg::CLS_TBL_RD) |=>
        (exec_addr == $past(accumulator_low_word)))
        else $error("table address not from accumulator low");
    AST_BLK_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
        (loop_start && dec_class == rpt_pkg::CLS_BLK_D2P) |=>
        (exec_addr == $past(block_move_address_register)))
        else $error("block move address not from block register");
    AST_MUL_MOVE: assert property (@(posedge aclk) disable iff (!aresetn)
        (exec_valid && exec_class == rpt_pkg::CLS_MUL_MOVE) |->
        (acc_add_product_register && treg_load && mult_pmem && data_move))
        else $error("multiply accumulate move step missing");
    AST_PEND: assert property (@(posedge aclk) disable iff (!aresetn)
        (irq_req[0] && masked) |=> pend_r[0] && (irq_out[0] == !masked))
        else $error("masked interrupt lost");

    COV_LOOP: cover property (@(posedge aclk) disable iff (!aresetn)
        loop_start ##[1:20] exec_last);
    COV_HOLD: cover property (@(posedge aclk) disable iff (!aresetn)
        hold_q_r && state_r == rpt_pkg::S_RUN);
    COV_TBL: cover property (@(posedge aclk) disable iff (!aresetn)
        loop_start && dec_class == rpt_pkg::CLS_TBL_RD);
    COV_IRQ: cover property (@(posedge aclk) disable iff (!aresetn)
        masked && irq_req[0] ##[1:30] irq_out[0]);
endmodule

// ==== single_instruction_repeat_unit_bench.sv ====
// self-checking bench for the single instruction repeat unit
`timescale 1ns/100ps
module single_instruction_repeat_unit_bench;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hold_req;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, d;
    logic [7:0]  irq_req, irq_ack;
    logic [15:0] acc, blk_addr, ea;
    logic [1:0]  r;
    wire         awready, wready, bvalid, arready, rvalid, dec_ready, ev, eo, amac, aclr, hold_ack;
    wire         dv, dl, dz, dr;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [2:0]  dc;
    wire  [15:0] dop, dad, exec_addr;
    wire  [7:0]  irq_out;
    int          mismatches = 0, checks = 0;
    single_instruction_repeat_unit single_instruction_repeat_unit_i (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .dec_valid(dv), .dec_ready(dec_ready), .dec_repeat_load(dl), .dec_repeat_zero(dz),
        .dec_repeatable(dr), .dec_class(dc), .dec_operand(dop), .dec_addr(dad),
        .accumulator_low_word(acc), .block_move_address_register(blk_addr), .exec_valid(ev),
        .exec_first(), .exec_last(), .exec_class(), .exec_addr(exec_addr), .exec_once(eo),
        .acc_clear(aclr), .acc_add_product_register(amac), .treg_load(), .mult_pmem(), .data_move(),
        .irq_req(irq_req), .irq_ack(irq_ack), .irq_out(irq_out), .hold_req(hold_req),
        .hold_ack(hold_ack));
    rpt_partner rpt_partner_i (.aclk(aclk), .dec_valid(dv), .dec_ready(dec_ready),
        .dec_repeat_load(dl), .dec_repeat_zero(dz), .dec_repeatable(dr), .dec_class(dc),
        .dec_operand(dop), .dec_addr(dad), .exec_valid(ev), .exec_addr(exec_addr),
        .exec_once(eo), .acc_add_product_register(amac), .acc_clear(aclr));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic timeout();
        mismatches++;
        print_verdict();
    endtask
    task automatic rd(input logic [3:0] a);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (i == 100) timeout();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        int i;
        @(posedge aclk);
        {awaddr, wdata} <= {a, v};
        {awvalid, wvalid, bready} <= 3'b111;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (awready === 1'b1) {awvalid, wvalid} <= 2'b00;
            if (bvalid === 1'b1) break;
        end
        if (i == 100) timeout();
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic wait_done();
        int i;
        for (i = 0; i < 70000; i++) begin
            @(posedge aclk);
            if (dec_ready === 1'b1) break;
        end
        if (i == 70000 || rpt_partner_i.lost) timeout();
    endtask
    // repeat load of n, then the instruction to repeat
    task automatic run(input logic z, rp, input logic [2:0] c, input logic [15:0] n, a);
        rpt_partner_i.clear();
        rpt_partner_i.issue(1'b1, z, 1'b0, 3'h0, n, 16'h0);
        rpt_partner_i.issue(1'b0, 1'b0, rp, c, 16'h0, a);
        wait_done();
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, hold_req} = 7'h0;
        {awaddr, araddr, irq_req, irq_ack} = 24'h0;
        wdata = 32'h0;
        acc = 16'h1230;
        blk_addr = 16'h0400;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(rpt_pkg::OFS_COUNT);
        chk(d, 32'h0);
        rd(4'hc);
        chk(r, rpt_pkg::RESP_SLVERR);
        wr(4'h8, 32'h1);
        chk(r, rpt_pkg::RESP_SLVERR);
        // software keeps off the count register, status writes must not disturb it
        wr(rpt_pkg::OFS_STATUS, 32'h1f);
        chk(r, rpt_pkg::RESP_OKAY);
        rd(rpt_pkg::OFS_COUNT);
        chk(d, 32'h0);
        $display("test registers done");
        rpt_partner_i.clear();
        rpt_partner_i.issue(1'b1, 1'b0, 1'b0, 3'h0, 16'h0003, 16'h0);
        rd(rpt_pkg::OFS_COUNT);
        chk(d, 32'h3);
        irq_req <= 8'h81;
        @(posedge aclk);
        irq_req <= 8'h00;
        rpt_partner_i.issue(1'b0, 1'b0, 1'b1, 3'h0, 16'h0, 16'h0);
        chk(irq_out, 8'h00);
        wait_done();
        chk(rpt_partner_i.n_exec, 4);
        rd(rpt_pkg::OFS_COUNT);
        chk(d, 32'h0);
        chk(irq_out, 8'h81);
        irq_ack <= 8'h81;
        @(posedge aclk);
        irq_ack <= 8'h00;
        @(posedge aclk);
        chk(irq_out, 8'h00);
        $display("test count and mask done");
        // start address by class: accumulator, block address or operand
        for (int c = 1; c < 8; c++) begin
            ea = (c < 3) ? acc : (c == 3) ? blk_addr : 16'h0080;
            run(c == 6, 1'b1, 3'(c), 16'h0002, 16'h0080);
            chk(rpt_partner_i.n_exec, 3);
            chk(rpt_partner_i.a_first, ea);
            chk(rpt_partner_i.a_last, ea + 16'h2);
            chk(rpt_partner_i.t_last - rpt_partner_i.t_first, 2);
            if (c == 6) chk(rpt_partner_i.n_acc_add, 3);
            if (c == 6) chk(rpt_partner_i.n_clr, 1);
        end
        $display("test classes done");
        run(1'b0, 1'b0, 3'h0, 16'h0004, 16'h0);
        chk(rpt_partner_i.n_once, 1);
        chk(rpt_partner_i.n_exec, 0);
        rd(rpt_pkg::OFS_STATUS);
        chk(d[rpt_pkg::ST_REJECT], 1'b1);
        $display("test reject done");
        fork
            run(1'b0, 1'b1, 3'h7, 16'h0007, 16'h0);
            begin
                repeat (4) @(posedge aclk);
                hold_req <= 1'b1;
                repeat (6) @(posedge aclk);
                chk(hold_ack, 1'b1);
                hold_req <= 1'b0;
            end
        join
        chk(rpt_partner_i.n_exec, 8);
        // hold pauses iterations, so eight executions span more than seven cycles
        chk(rpt_partner_i.t_last - rpt_partner_i.t_first > 7, 1'b1);
        $display("test hold done");
        // longest loop the counter can hold
        run(1'b0, 1'b1, 3'h0, 16'hffff, 16'h0);
        chk(rpt_partner_i.n_exec, 65536);
        $display("test full range done");
        print_verdict();
    end
endmodule
